// >>> verilog/bba_defs.svh
/*
 * Register offsets, field positions, reset values and digit constants of the
 * BCD/binary arithmetic unit.
 * Assumes inclusion by bare name from every file that needs the numbers.
 */
`ifndef BBA_DEFS_SVH
`define BBA_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define BBA_OFS_CMD     12'h000
`define BBA_OFS_OPND    12'h004
`define BBA_OFS_ACC     12'h008
`define BBA_OFS_STK     12'h00C
`define BBA_OFS_STATUS  12'h010

// ----------------------------------------------------------------------------
// command fields and codes
// ----------------------------------------------------------------------------
`define BBA_CMD_OP_LSB    0
`define BBA_CMD_MODE_LSB  4
`define BBA_OP_BCD_DIVIDE_DOUBLE       3'h0
`define BBA_OP_INC        3'h1
`define BBA_OP_DEC        3'h2
`define BBA_OP_BIN_PLUS_ONE       3'h3
`define BBA_OP_BIN_MINUS_ONE       3'h4
`define BBA_OP_ADD_BINARY_OP       3'h5
`define BBA_OP_SUBTRACT_BINARY_OP       3'h6
`define BBA_MODE_MEM      2'h0
`define BBA_MODE_PTR      2'h1
`define BBA_MODE_CONST    2'h2

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define BBA_F_ZERO     0
`define BBA_F_NEG      1
`define BBA_F_NONBCD   2
`define BBA_F_TOOBIG   3
`define BBA_F_C16      4
`define BBA_F_C32      5
`define BBA_F_B16      6
`define BBA_F_B32      7
`define BBA_F_SOVF     8
`define BBA_NFLAGS     9
`define BBA_ST_BUSY    16
`define BBA_ST_REJECT  17

// ----------------------------------------------------------------------------
// reset values and digit constants
// ----------------------------------------------------------------------------
`define BBA_RST_WORD   32'h0000_0000
`define BBA_DIGIT_MAX  5'h09
`define BBA_DIGIT_TEN  4'hA
`define BBA_DIGIT_ADJ  4'h6
`define BBA_DIV_DIGITS 4'h8

`endif

// >>> verilog/bba_pkg.sv
/*
 * Types of the BCD/binary arithmetic unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bba_pkg;

  typedef enum logic [3:0] {
    BBA_IDLE,
    BBA_PTR,
    BBA_RD_LO,
    BBA_RD_HI,
    BBA_EXEC,
    BBA_DIV_SHIFT,
    BBA_DIV_SUB,
    BBA_FIN,
    BBA_WRITE
  } bba_state_t;

endpackage

// >>> verilog/bba_bcd_addsub.sv
/*
 * Packed-BCD adder/subtractor, one digit slice per generate entry.
 * Assumes the caller ignores the result when bad is high.
 */
`timescale 1ns/1ns
`include "bba_defs.svh"

module bba_bcd_addsub
  import bba_pkg::*;
#(
  parameter int DIGITS = 9
) (
  input  wire logic [4*DIGITS-1:0] a,
  input  wire logic [4*DIGITS-1:0] b,
  input  wire logic                sub,
  output logic      [4*DIGITS-1:0] y,
  output logic                     cout,
  output logic                     bad
);

  logic [DIGITS:0]   cy;
  logic [DIGITS-1:0] bad_d;

  assign cy[0] = 1'b0;

  genvar i;
  for (i = 0; i < DIGITS; i = i + 1) begin : g_dig
    logic [3:0] da;
    logic [3:0] db;
    logic [4:0] raw;
    assign da        = a[4*i+:4];
    assign db        = b[4*i+:4];
    assign raw       = sub ? ({1'b0, da} - {1'b0, db} - {4'h0, cy[i]})
                           : ({1'b0, da} + {1'b0, db} + {4'h0, cy[i]});
    assign cy[i+1]   = sub ? raw[4] : (raw > `BBA_DIGIT_MAX);
    // borrow adds ten back, decimal carry skips the six unused codes
    assign y[4*i+:4] = sub ? (raw[4] ? raw[3:0] + `BBA_DIGIT_TEN : raw[3:0])
                           : (cy[i+1] ? raw[3:0] + `BBA_DIGIT_ADJ : raw[3:0]);
    assign bad_d[i]  = ({1'b0, da} > `BBA_DIGIT_MAX) || ({1'b0, db} > `BBA_DIGIT_MAX);
  end

  assign cout = cy[DIGITS];
  assign bad  = |bad_d;

endmodule // bba_bcd_addsub

// >>> verilog/bba_arith_unit.sv
/*
 * BCD/binary arithmetic unit: double BCD divide, BCD and binary increment
 * and decrement of a memory word, binary add and subtract, status flags.
 * Assumes an APB master for commands and a word memory that answers each
 * held read or write request with a one-cycle mem_ack.
 */
`timescale 1ns/1ns
`include "bba_defs.svh"

module bba_arith_unit
  import bba_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        mem_rd,
  output logic                        mem_wr,
  output logic      [AW-1:0]          mem_addr,
  output logic      [15:0]            mem_wdata,
  input  wire logic [15:0]            mem_rdata,
  input  wire logic                   mem_ack,
  output logic      [`BBA_NFLAGS-1:0] status_flags,
  output logic                        op_done
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  bba_state_t              state_q;
  logic [2:0]              op_q;
  logic [1:0]              mode_q;
  logic [15:0]             opnd_q;
  logic [AW-1:0]           addr_q;
  logic [15:0]             w_lo_q;
  logic [15:0]             w_hi_q;
  logic [31:0]             acc_q;
  logic [31:0]             stk_q;
  logic [31:0]             dvd_q;
  logic [31:0]             quot_q;
  logic [35:0]             rem_q;
  logic [3:0]              qd_q;
  logic [3:0]              cnt_q;
  logic [`BBA_NFLAGS-1:0]  flags_q;
  logic                    reject_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic [31:0]             prdata_q;
  logic                    mem_rd_q;
  logic                    mem_wr_q;
  logic [15:0]             mem_wdata_q;
  logic                    done_q;

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic        wr_fire;
  logic        cmd_fire;
  logic        cmd_legal;
  logic [2:0]  cmd_op;
  logic [1:0]  cmd_mode;
  logic        idle;

  assign idle      = (state_q == BBA_IDLE);
  assign wr_fire   = psel & penable & pwrite & pready_q;
  assign cmd_op    = pwdata[`BBA_CMD_OP_LSB+:3];
  assign cmd_mode  = pwdata[`BBA_CMD_MODE_LSB+:2];
  // constants only for add/subtract; divide refuses a constant divisor
  assign cmd_legal = (cmd_op <= `BBA_OP_SUBTRACT_BINARY_OP) && (cmd_mode != 2'h3) &&
                     ((cmd_mode != `BBA_MODE_CONST) || (cmd_op == `BBA_OP_ADD_BINARY_OP) ||
                      (cmd_op == `BBA_OP_SUBTRACT_BINARY_OP));
  assign cmd_fire  = wr_fire && (paddr == `BBA_OFS_CMD);

  logic        map_hit;
  logic [31:0] rd_mux;

  always_comb begin
    map_hit = 1'b1;
    rd_mux  = `BBA_RST_WORD;
    case (paddr)
      `BBA_OFS_CMD:    rd_mux = {26'h0, mode_q, 1'b0, op_q};
      `BBA_OFS_OPND:   rd_mux = {16'h0, opnd_q};
      `BBA_OFS_ACC:    rd_mux = acc_q;
      `BBA_OFS_STK:    rd_mux = stk_q;
      `BBA_OFS_STATUS: rd_mux = {14'h0, reject_q, !idle, 7'h0, flags_q};
      default:         map_hit = 1'b0;
    endcase
  end

  // zero-wait slave: answer is set up in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `BBA_RST_WORD;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~map_hit;
      prdata_q  <= (psel & ~penable & ~pwrite) ? rd_mux : `BBA_RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_q <= 16'h0000;
    end else if (wr_fire && paddr == `BBA_OFS_OPND) begin
      opnd_q <= pwdata[15:0];
    end
  end

  // refused command is sticky; a new refusal wins over the clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_q <= 1'b0;
    end else if (cmd_fire && (!idle || !cmd_legal)) begin
      reject_q <= 1'b1;
    end else if (wr_fire && paddr == `BBA_OFS_STATUS && pwdata[`BBA_ST_REJECT]) begin
      reject_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // arithmetic
  // --------------------------------------------------------------------------
  logic [35:0] bcd_a;
  logic [35:0] bcd_b;
  logic [35:0] bcd_y;
  logic        bcd_sub;
  logic        bcd_bad;
  logic        is_div;

  assign is_div  = (op_q == `BBA_OP_BCD_DIVIDE_DOUBLE);
  assign bcd_a   = is_div ? rem_q : {20'h0, w_lo_q};
  assign bcd_b   = is_div ? {4'h0, w_hi_q, w_lo_q} : 36'h0_0000_0001;
  assign bcd_sub = is_div || (op_q == `BBA_OP_DEC);

  bba_bcd_addsub #(
    .DIGITS (9)
  ) u_bcd (
    .a    (bcd_a),
    .b    (bcd_b),
    .sub  (bcd_sub),
    .y    (bcd_y),
    .cout (),
    .bad  (bcd_bad)
  );

  logic [15:0] opval;
  logic [16:0] sum17;
  logic [32:0] diff33;
  logic [31:0] dvs;
  logic        acc_bad;

  assign opval  = (mode_q == `BBA_MODE_CONST) ? opnd_q : w_lo_q;
  assign sum17  = {1'b0, acc_q[15:0]} + {1'b0, opval};
  assign diff33 = {1'b0, acc_q} - {17'h0_0000, opval};
  assign dvs    = {w_hi_q, w_lo_q};

  always_comb begin
    acc_bad = 1'b0;
    for (int k = 0; k < 8; k++) begin
      acc_bad = acc_bad | ({1'b0, acc_q[4*k+:4]} > `BBA_DIGIT_MAX);
    end
  end

  // --------------------------------------------------------------------------
  // sequencer and datapath registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= BBA_IDLE;
      op_q        <= `BBA_OP_BCD_DIVIDE_DOUBLE;
      mode_q      <= `BBA_MODE_MEM;
      addr_q      <= '0;
      w_lo_q      <= 16'h0000;
      w_hi_q      <= 16'h0000;
      acc_q       <= `BBA_RST_WORD;
      stk_q       <= `BBA_RST_WORD;
      dvd_q       <= `BBA_RST_WORD;
      quot_q      <= `BBA_RST_WORD;
      rem_q       <= 36'h0_0000_0000;
      qd_q        <= 4'h0;
      cnt_q       <= 4'h0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 16'h0000;
      done_q      <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        BBA_IDLE: begin
          if (wr_fire && paddr == `BBA_OFS_ACC) begin
            acc_q <= pwdata;
          end
          if (wr_fire && paddr == `BBA_OFS_STK) begin
            stk_q <= pwdata;
          end
          if (cmd_fire && cmd_legal) begin
            op_q   <= cmd_op;
            mode_q <= cmd_mode;
            addr_q <= opnd_q[AW-1:0];
            if (cmd_mode == `BBA_MODE_CONST) begin
              state_q <= BBA_EXEC;
            end else begin
              mem_rd_q <= 1'b1;
              state_q  <= (cmd_mode == `BBA_MODE_PTR) ? BBA_PTR : BBA_RD_LO;
            end
          end
        end
        BBA_PTR: begin
          if (mem_ack) begin
            addr_q  <= mem_rdata[AW-1:0];
            state_q <= BBA_RD_LO;
          end
        end
        BBA_RD_LO: begin
          if (mem_ack) begin
            w_lo_q <= mem_rdata;
            if (is_div) begin
              addr_q  <= addr_q + 1'b1;
              state_q <= BBA_RD_HI;
            end else begin
              mem_rd_q <= 1'b0;
              state_q  <= BBA_EXEC;
            end
          end
        end
        BBA_RD_HI: begin
          if (mem_ack) begin
            w_hi_q   <= mem_rdata;
            mem_rd_q <= 1'b0;
            state_q  <= BBA_EXEC;
          end
        end
        BBA_EXEC: begin
          state_q <= BBA_IDLE;
          done_q  <= 1'b1;
          case (op_q)
            `BBA_OP_BCD_DIVIDE_DOUBLE: begin
              if (!acc_bad && !bcd_bad && dvs != 32'h0000_0000) begin
                dvd_q   <= acc_q;
                quot_q  <= `BBA_RST_WORD;
                rem_q   <= 36'h0_0000_0000;
                cnt_q   <= `BBA_DIV_DIGITS;
                done_q  <= 1'b0;
                state_q <= BBA_DIV_SHIFT;
              end
            end
            `BBA_OP_INC, `BBA_OP_DEC: begin
              if (!bcd_bad) begin
                mem_wdata_q <= bcd_y[15:0];
                mem_wr_q    <= 1'b1;
                done_q      <= 1'b0;
                state_q     <= BBA_WRITE;
              end
            end
            `BBA_OP_BIN_PLUS_ONE, `BBA_OP_BIN_MINUS_ONE: begin
              mem_wdata_q <= (op_q == `BBA_OP_BIN_PLUS_ONE) ? w_lo_q + 16'h0001
                                                    : w_lo_q - 16'h0001;
              mem_wr_q    <= 1'b1;
              done_q      <= 1'b0;
              state_q     <= BBA_WRITE;
            end
            `BBA_OP_ADD_BINARY_OP: acc_q <= {15'h0000, sum17};
            `BBA_OP_SUBTRACT_BINARY_OP: acc_q <= diff33[31:0];
            default: ;
          endcase
        end
        BBA_DIV_SHIFT: begin
          // bring down the next dividend digit
          rem_q   <= {rem_q[31:0], dvd_q[31:28]};
          dvd_q   <= {dvd_q[27:0], 4'h0};
          qd_q    <= 4'h0;
          state_q <= BBA_DIV_SUB;
        end
        BBA_DIV_SUB: begin
          // packed valid BCD compares like binary
          if (rem_q >= bcd_b) begin
            rem_q <= bcd_y;
            qd_q  <= qd_q + 4'h1;
          end else begin
            quot_q  <= {quot_q[27:0], qd_q};
            cnt_q   <= cnt_q - 4'h1;
            state_q <= (cnt_q == 4'h1) ? BBA_FIN : BBA_DIV_SHIFT;
          end
        end
        BBA_FIN: begin
          acc_q   <= quot_q;
          stk_q   <= rem_q[31:0];
          done_q  <= 1'b1;
          state_q <= BBA_IDLE;
        end
        BBA_WRITE: begin
          if (mem_ack) begin
            mem_wr_q <= 1'b0;
            done_q   <= 1'b1;
            state_q  <= BBA_IDLE;
          end
        end
        default: state_q <= BBA_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------------------
  // each operation rewrites its own flags and keeps all others
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else if (state_q == BBA_EXEC) begin
      case (op_q)
        `BBA_OP_BCD_DIVIDE_DOUBLE: begin
          flags_q[`BBA_F_NONBCD] <= acc_bad | bcd_bad;
          flags_q[`BBA_F_TOOBIG] <= !(acc_bad | bcd_bad) && (dvs == 32'h0000_0000);
          flags_q[`BBA_F_NEG]    <= 1'b0;
          flags_q[`BBA_F_ZERO]   <= (acc_q == 32'h0000_0000);
        end
        `BBA_OP_INC, `BBA_OP_DEC: begin
          flags_q[`BBA_F_NONBCD] <= bcd_bad;
          flags_q[`BBA_F_ZERO]   <= !bcd_bad && (bcd_y[15:0] == 16'h0000);
        end
        `BBA_OP_BIN_PLUS_ONE: flags_q[`BBA_F_ZERO] <= (w_lo_q == 16'hFFFF);
        `BBA_OP_BIN_MINUS_ONE: flags_q[`BBA_F_ZERO] <= (w_lo_q == 16'h0001);
        `BBA_OP_ADD_BINARY_OP: begin
          flags_q[`BBA_F_ZERO] <= (sum17 == 17'h0_0000);
          flags_q[`BBA_F_NEG]  <= 1'b0;
          flags_q[`BBA_F_C16]  <= sum17[16];
          flags_q[`BBA_F_C32]  <= 1'b0;
          flags_q[`BBA_F_SOVF] <= (acc_q[15] == opval[15]) &&
                                  (sum17[15] != acc_q[15]);
        end
        `BBA_OP_SUBTRACT_BINARY_OP: begin
          flags_q[`BBA_F_ZERO] <= (diff33[31:0] == 32'h0000_0000);
          flags_q[`BBA_F_NEG]  <= diff33[31];
          flags_q[`BBA_F_B16]  <= (acc_q[15:0] < opval);
          flags_q[`BBA_F_B32]  <= diff33[32];
          flags_q[`BBA_F_SOVF] <= acc_q[31] & ~diff33[31];
        end
        default: ;
      endcase
    end else if (state_q == BBA_FIN) begin
      flags_q[`BBA_F_ZERO] <= (quot_q == 32'h0000_0000);
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign mem_rd       = mem_rd_q;
  assign mem_wr       = mem_wr_q;
  assign mem_addr     = addr_q;
  assign mem_wdata    = mem_wdata_q;
  assign status_flags = flags_q;
  assign op_done      = done_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_result: assert property (state_q == BBA_FIN |=>
    acc_q == $past(quot_q) && stk_q == $past(rem_q[31:0]))
    else $error("divide result not placed");
  a_div_toobig: assert property (state_q == BBA_EXEC && is_div && !acc_bad
    && !bcd_bad && dvs == 32'h0000_0000 |=> flags_q[`BBA_F_TOOBIG] && idle)
    else $error("zero divisor not flagged");
  a_zero_div: assert property (state_q == BBA_FIN |=>
    flags_q[`BBA_F_ZERO] == (acc_q == 32'h0000_0000))
    else $error("zero flag wrong after divide");
  a_neg_subtract_binary_op: assert property (state_q == BBA_EXEC && op_q == `BBA_OP_SUBTRACT_BINARY_OP |=>
    flags_q[`BBA_F_NEG] == acc_q[31])
    else $error("negative flag wrong");
  a_nonbcd_abort: assert property (state_q == BBA_EXEC && bcd_bad &&
    (op_q == `BBA_OP_INC || op_q == `BBA_OP_DEC)
    |=> flags_q[`BBA_F_NONBCD] && idle && !mem_wr_q)
    else $error("bad digit not flagged");
  a_bin_plus_one_wb: assert property (state_q == BBA_EXEC && op_q == `BBA_OP_BIN_PLUS_ONE |=>
    mem_wr_q && mem_wdata_q == $past(w_lo_q) + 16'h0001 && $stable(flags_q[8:1]))
    else $error("binary increment wrong");
  a_add_binary_op_c16: assert property (state_q == BBA_EXEC && op_q == `BBA_OP_ADD_BINARY_OP |=>
    flags_q[`BBA_F_C16] == acc_q[16] && acc_q[31:17] == 15'h0000)
    else $error("add carry wrong");
  a_subtract_binary_op_b32: assert property (state_q == BBA_EXEC && op_q == `BBA_OP_SUBTRACT_BINARY_OP |=>
    flags_q[`BBA_F_B32] == ($past(acc_q) < {16'h0000, $past(opval)}))
    else $error("subtract borrow wrong");
  a_ptr_addr: assert property (state_q == BBA_PTR && mem_ack |=>
    mem_addr == $past(mem_rdata[AW-1:0]) && mem_rd_q)
    else $error("pointer not followed");

  c_div_done: cover property (state_q == BBA_FIN ##1 done_q);
  c_ptr_used: cover property (state_q == BBA_PTR ##1 state_q == BBA_RD_LO);
  c_bcd_wb:   cover property (state_q == BBA_WRITE && mem_ack && op_q == `BBA_OP_DEC);

endmodule // bba_arith_unit

// >>> sim/bba_mem_model.sv
/* word memory beside the arithmetic unit: acks each held request with a pulse.
   assumes requests and address held until the ack edge. */
`timescale 1ns/1ns

module bba_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  slow,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_q;
  // ----------------------------------------------------------------
  // handshake, slow cycles of extra wait before each ack
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if ((mem_rd || mem_wr) && !mem_ack && wait_q == slow) begin
      mem_ack   <= 1'b1;
      wait_q    <= 2'h0;
      if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
      mem_rdata <= mem_wr ? ~mem_rdata : mem[mem_addr[7:0]];
    end else begin
      mem_ack   <= 1'b0;
      wait_q    <= ((mem_rd || mem_wr) && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      // stale word inverted each cycle except the ack cycle of a read
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // bba_mem_model

// >>> sim/bba_arith_unit_tb_top.sv
/* self-checking bench of bba_arith_unit: APB command tasks and scenarios.
   assumes bba_mem_model as the word memory. */
`timescale 1ns/1ns
`include "bba_defs.svh"

module bba_arith_unit_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        mem_rd, mem_wr, mem_ack, op_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [8:0]  status_flags;
  logic [1:0]  slow;
  int          miscompares = 0;
  int          checks = 0;

  bba_arith_unit #(.AW(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .status_flags(status_flags), .op_done(op_done));
  bba_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .slow(slow), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic [8:0] m, input logic [8:0] e);
    chk({23'h0, status_flags & m}, {23'h0, e & m});
  endtask

  task automatic chkm(input logic [7:0] a, input logic [15:0] e);
    chk({16'h0000, u_mem.mem[a]}, {16'h0000, e});
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: no pready", $time);
      stop_test();
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic run(input logic [2:0] op, input logic [1:0] md, input logic [15:0] opnd);
    int n;
    n = 0;
    apb(1'b1, `BBA_OFS_OPND, {16'h0000, opnd});
    apb(1'b1, `BBA_OFS_CMD, {26'h0, md, 1'b0, op});
    do begin
      @(posedge pclk);
      n++;
    end while (op_done !== 1'b1 && n < 2000);
    if (op_done !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: no op_done", $time);
      stop_test();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, slow} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    u_mem.mem[8'h10] = 16'h0099;
    run(`BBA_OP_INC, `BBA_MODE_MEM, 16'h0010);
    chkm(8'h10, 16'h0100);
    u_mem.mem[8'h10] = 16'h9999;
    run(`BBA_OP_INC, `BBA_MODE_MEM, 16'h0010);
    chkm(8'h10, 16'h0000);
    chkf(9'h005, 9'h001);
    slow <= 2'h2;
    u_mem.mem[8'h11] = 16'h0000;
    run(`BBA_OP_DEC, `BBA_MODE_MEM, 16'h0011);
    chkm(8'h11, 16'h9999);
    chkf(9'h005, 9'h000);
    u_mem.mem[8'h12] = 16'h00A0;
    run(`BBA_OP_DEC, `BBA_MODE_MEM, 16'h0012);
    chkm(8'h12, 16'h00A0);
    chkf(9'h004, 9'h004);
    u_mem.mem[8'h13] = 16'h0020;
    u_mem.mem[8'h20] = 16'hFFFF;
    run(`BBA_OP_BIN_PLUS_ONE, `BBA_MODE_PTR, 16'h0013);
    chkm(8'h20, 16'h0000);
    chkf(9'h005, 9'h005);
    slow <= 2'h0;
    u_mem.mem[8'h21] = 16'h0000;
    run(`BBA_OP_BIN_MINUS_ONE, `BBA_MODE_MEM, 16'h0021);
    chkm(8'h21, 16'hFFFF);
    chkf(9'h005, 9'h004);
    apb(1'b1, `BBA_OFS_ACC, 32'h1234_FFFF);
    run(`BBA_OP_ADD_BINARY_OP, `BBA_MODE_CONST, 16'h0001);
    rdc(`BBA_OFS_ACC, 32'h0001_0000);
    chkf(9'h131, 9'h010);
    apb(1'b1, `BBA_OFS_ACC, 32'h0000_7FFF);
    u_mem.mem[8'h22] = 16'h0001;
    run(`BBA_OP_ADD_BINARY_OP, `BBA_MODE_MEM, 16'h0022);
    rdc(`BBA_OFS_ACC, 32'h0000_8000);
    chkf(9'h111, 9'h100);
    apb(1'b1, `BBA_OFS_ACC, 32'h0000_0005);
    run(`BBA_OP_SUBTRACT_BINARY_OP, `BBA_MODE_CONST, 16'h0006);
    rdc(`BBA_OFS_ACC, 32'hFFFF_FFFF);
    chkf(9'h1C3, 9'h0C2);
    apb(1'b1, `BBA_OFS_ACC, 32'h8000_0000);
    run(`BBA_OP_SUBTRACT_BINARY_OP, `BBA_MODE_CONST, 16'h0001);
    rdc(`BBA_OFS_ACC, 32'h7FFF_FFFF);
    chkf(9'h1C3, 9'h140);
    slow <= 2'h1;
    apb(1'b1, `BBA_OFS_ACC, 32'h0000_0100);
    u_mem.mem[8'h30] = 16'h0007;
    u_mem.mem[8'h31] = 16'h0000;
    run(`BBA_OP_BCD_DIVIDE_DOUBLE, `BBA_MODE_MEM, 16'h0030);
    rdc(`BBA_OFS_ACC, 32'h0000_0014);
    rdc(`BBA_OFS_STK, 32'h0000_0002);
    chkf(9'h00F, 9'h000);
    apb(1'b1, `BBA_OFS_ACC, 32'h0012_0003);
    u_mem.mem[8'h34] = 16'h0000;
    u_mem.mem[8'h35] = 16'h0001;
    run(`BBA_OP_BCD_DIVIDE_DOUBLE, `BBA_MODE_PTR - 2'h1, 16'h0034);
    rdc(`BBA_OFS_ACC, 32'h0000_0012);
    rdc(`BBA_OFS_STK, 32'h0000_0003);
    u_mem.mem[8'h35] = 16'h0000;
    run(`BBA_OP_BCD_DIVIDE_DOUBLE, `BBA_MODE_MEM, 16'h0034);
    chkf(9'h008, 9'h008);
    rdc(`BBA_OFS_ACC, 32'h0000_0012);
    apb(1'b1, `BBA_OFS_CMD, {26'h0, `BBA_MODE_CONST, 1'b0, `BBA_OP_BCD_DIVIDE_DOUBLE});
    rdc(`BBA_OFS_STATUS, 32'h0002_0148);
    apb(1'b1, `BBA_OFS_STATUS, 32'h0002_0000);
    rdc(`BBA_OFS_STATUS, 32'h0000_0148);
    rdc(12'h020, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    stop_test();
  end
endmodule // bba_arith_unit_tb_top
